/* File: tb/host_port_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module host_port_chk (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [1:0] reg_select,
  input wire logic read_not_write,
  input wire logic chip_select_n,
  input wire logic data_strobe_n,
  input wire logic halfword_identify,
  input wire logic bus_from_bridge_oe,
  input wire logic port_ready_n
);
  import hport_pkg::*;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_first_done;
    !data_strobe_n && !port_ready_n && !halfword_identify;
  endsequence
  sequence s_second_done;
    !data_strobe_n && !port_ready_n && halfword_identify;
  endsequence
  a_strobe_hold: assert property (!data_strobe_n && port_ready_n |=> !data_strobe_n && $stable(halfword_identify))
    else $error("strobe or identify moved before ready");
  a_ready_bound: assert property ($fell(data_strobe_n) |-> ##[1:8] data_strobe_n)
    else $error("strobe not released within the ready wait");
  a_first_half: assert property (s_first_done |=> data_strobe_n ##1 (halfword_identify && !chip_select_n))
    else $error("first half not followed by second half");
  a_second_half: assert property (s_second_done |=> data_strobe_n ##1 chip_select_n)
    else $error("select not released after second half");
  a_select_strobe: assert property (!data_strobe_n |-> !chip_select_n && reg_select != SEL_DATA_INC)
    else $error("strobe without select or with increment");
  a_write_drive: assert property (!data_strobe_n && !read_not_write |-> bus_from_bridge_oe)
    else $error("write strobe without bus driven");
  a_read_release: assert property (!data_strobe_n && read_not_write |-> !bus_from_bridge_oe)
    else $error("read strobe with bus driven");
  a_pair_stable: assert property (!chip_select_n && !$past(chip_select_n) |-> $stable(reg_select) && $stable(read_not_write))
    else $error("select or direction changed inside a pair");
  a_close_after: assert property ($rose(chip_select_n) |-> $past(halfword_identify))
    else $error("transaction closed before second half");
endmodule // host_port_chk
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import hport_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic cmd_valid_in = 1'b0;
  logic cmd_ready_out;
  logic [CMD_W-1:0] cmd_kind_in = CMD_CONTROL;
  logic [WORD_W-1:0] cmd_data_in = 32'h0000_0000;
  logic [3:0] cmd_byte_en_in = 4'hF;
  logic rd_valid_out;
  logic rd_ready_in = 1'b0;
  logic [WORD_W-1:0] rd_data_out, control_out, address_out, word_out, read_fetch_addr_out, last_word;
  logic [WORD_W-1:0] read_word_in = 32'h0000_0000;
  logic [1:0] setup_done_out;
  logic core_reset_in = 1'b0;
  logic word_valid_out, pair_lost_out;
  logic lost_seen = 1'b0;
  logic [3:0] word_be_out, last_be;
  int mismatches = 0;
  int tests_run = 0;
  int words_seen = 0;
  host_port_if hp_if();
  host_port_bridge i_host_port_bridge (.mclk_in, .rst_n_in, .cmd_valid_in, .cmd_ready_out, .cmd_kind_in,
    .cmd_data_in, .cmd_byte_en_in, .rd_valid_out, .rd_ready_in, .rd_data_out, .setup_done_out, .hp(hp_if));
  host_port_dsp i_host_port_dsp (.mclk_in, .rst_n_in, .core_reset_in, .control_out, .address_out,
    .word_valid_out, .word_out, .word_be_out, .read_fetch_addr_out, .read_word_in, .pair_lost_out, .hp(hp_if));
  host_port_chk i_host_port_chk (.mclk_in, .rst_n_in, .reg_select(hp_if.reg_select),
    .read_not_write(hp_if.read_not_write), .chip_select_n(hp_if.chip_select_n),
    .data_strobe_n(hp_if.data_strobe_n), .halfword_identify(hp_if.halfword_identify),
    .bus_from_bridge_oe(hp_if.bus_from_bridge_oe), .port_ready_n(hp_if.port_ready_n));
  always #20 mclk_in = ~mclk_in;
  // The completed-word pulse lasts one cycle, so it is latched here rather than polled by the tests.
  always @(posedge mclk_in) begin
    if (word_valid_out === 1'b1) begin
      words_seen <= words_seen + 1;
      last_word <= word_out;
      last_be <= word_be_out;
    end
    if (pair_lost_out === 1'b1) lost_seen <= 1'b1;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Waits for the whole transaction so that read data can change safely between commands.
  task automatic send(input logic [CMD_W-1:0] kind, input logic [31:0] data, input logic [3:0] be);
    int n;
    cmd_valid_in <= 1'b1;
    cmd_kind_in <= kind;
    cmd_data_in <= data;
    cmd_byte_en_in <= be;
    n = 0;
    do begin @(posedge mclk_in); n++; end while (cmd_ready_out !== 1'b1 && n < 50);
    check("command taken", 32'(n < 50), 32'h0000_0001);
    cmd_valid_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    n = 0;
    while (hp_if.chip_select_n !== 1'b1 && n < 50) begin @(posedge mclk_in); n++; end
    repeat (2) @(posedge mclk_in);
  endtask
  task automatic t_setup();
    cmd_kind_in <= CMD_WRITE;
    cmd_valid_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    check("data refused", 32'(cmd_ready_out), 32'h0000_0000);
    send(CMD_CONTROL, 32'h0000_0002, 4'hF);
    check("control done", 32'(setup_done_out), 32'h0000_0001);
    check("control value", control_out, 32'h0000_0002);
    send(CMD_ADDRESS, 32'h0000_0100, 4'hF);
    check("setup done", 32'(setup_done_out), 32'h0000_0003);
    check("address value", address_out, 32'h0000_0100);
    check("fetch address", read_fetch_addr_out, 32'h0000_0100);
    $display("test setup done");
  endtask
  task automatic t_write();
    logic [31:0] d [3] = '{32'hBBAA_1234, 32'h5566_7788, 32'hC3C3_0F0F};
    logic [3:0] b [3] = '{4'hF, 4'h4, 4'hC};
    logic [31:0] m;
    int n;
    for (int i = 0; i < 3; i++) begin
      n = words_seen;
      send(CMD_WRITE, d[i], b[i]);
      m = {{8{b[i][3]}}, {8{b[i][2]}}, {8{b[i][1]}}, {8{b[i][0]}}};
      check("word count", 32'(words_seen - n), 32'h0000_0001);
      check("word enables", 32'(last_be), 32'(b[i]));
      check("word data", last_word & m, d[i] & m);
    end
    $display("test write done");
  endtask
  task automatic t_read();
    int n;
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      read_word_in <= 32'hA000_0000 + 32'(i) * 32'h0001_0101;
      send(CMD_READ, 32'h0000_0000, 4'h0);
    end
    cmd_kind_in <= CMD_READ;
    cmd_valid_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    check("full refused", 32'(cmd_ready_out), 32'h0000_0000);
    cmd_valid_in <= 1'b0;
    rd_ready_in <= 1'b1;
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      n = 0;
      do begin @(posedge mclk_in); n++; end while (rd_valid_out !== 1'b1 && n < 20);
      check("read word", rd_data_out, 32'hA000_0000 + 32'(i) * 32'h0001_0101);
    end
    rd_ready_in <= 1'b0;
    @(posedge mclk_in);
    check("read empty", 32'(rd_valid_out), 32'h0000_0000);
    $display("test read done");
  endtask
  // A core held in reset never answers, so the strobe hangs until the bridge itself is reset.
  task automatic t_core_hold();
    int n;
    n = words_seen;
    core_reset_in <= 1'b1;
    cmd_kind_in <= CMD_WRITE;
    cmd_data_in <= 32'h1357_9BDF;
    cmd_byte_en_in <= 4'hF;
    cmd_valid_in <= 1'b1;
    @(posedge mclk_in);
    cmd_valid_in <= 1'b0;
    repeat (6) @(posedge mclk_in);
    check("strobe held", 32'(hp_if.data_strobe_n), 32'h0000_0000);
    check("ready held", 32'(hp_if.port_ready_n), 32'h0000_0001);
    check("no word", 32'(words_seen - n), 32'h0000_0000);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    check("reset select", 32'(hp_if.chip_select_n), 32'h0000_0001);
    check("reset strobe", 32'(hp_if.data_strobe_n), 32'h0000_0001);
    rst_n_in <= 1'b1;
    core_reset_in <= 1'b0;
    cmd_valid_in <= 1'b1;
    @(posedge mclk_in);
    check("setup cleared", 32'(setup_done_out), 32'h0000_0000);
    check("data refused again", 32'(cmd_ready_out), 32'h0000_0000);
    cmd_valid_in <= 1'b0;
    $display("test core hold done");
  endtask
  initial begin
    repeat (5) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    t_setup();
    t_write();
    t_read();
    t_core_hold();
    check("pair kept", 32'(lost_seen), 32'h0000_0000);
    close_out();
  end
  initial begin
    repeat (5000) @(posedge mclk_in);
    mismatches++;
    close_out();
  end
endmodule // tb_top
`default_nettype wire

/* File: verilog/host_port_bridge.sv */
`timescale 1ns/1ps
`default_nettype none
module host_port_bridge (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire logic [hport_pkg::CMD_W-1:0] cmd_kind_in,
  input wire logic [hport_pkg::WORD_W-1:0] cmd_data_in,
  input wire logic [3:0] cmd_byte_en_in,
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [hport_pkg::WORD_W-1:0] rd_data_out,
  output logic [1:0] setup_done_out,
  host_port_if.bridge hp
);
  import hport_pkg::*;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_STROBE = 3'b010,
    ST_RELEASE = 3'b011,
    ST_PUSH = 3'b100
  } state_t;
  state_t state_r;
  logic [CMD_W-1:0] kind_r;
  logic [WORD_W-1:0] word_r;
  logic [3:0] be_r;
  logic second_r;
  logic ctl_done_r;
  logic addr_done_r;
  logic [WORD_W-1:0] rd_word_r;
  logic push_valid_r;
  logic fifo_ready;
  logic is_data;
  logic cmd_legal;
  assign is_data = (cmd_kind_in == CMD_WRITE) || (cmd_kind_in == CMD_READ);
  // Data commands are held back until the control register and, after it, the address register were written.
  assign cmd_legal = !is_data || (ctl_done_r && addr_done_r);
  assign cmd_ready_out = (state_r == ST_IDLE) && cmd_legal && fifo_ready;
  assign setup_done_out = {addr_done_r, ctl_done_r};

  function automatic logic [1:0] sel_for(input logic [CMD_W-1:0] k);
    case (k)
      CMD_CONTROL: sel_for = SEL_CONTROL;
      CMD_ADDRESS: sel_for = SEL_ADDRESS;
      default: sel_for = SEL_DATA_NOINC;
    endcase
  endfunction

  // The low half of a word always travels first.
  function automatic logic [HALF_W-1:0] half_pick(input logic [WORD_W-1:0] w, input logic hi);
    half_pick = hi ? w[31:16] : w[15:0];
  endfunction

  // Returns the enable of byte lane 0 or 1 within the current half.
  function automatic logic lane_on(input logic [3:0] b, input logic hi, input logic lane);
    lane_on = b[{hi, lane}];
  endfunction

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctl_done_r <= 1'b0;
      addr_done_r <= 1'b0;
    end else if (state_r == ST_IDLE && cmd_valid_in && cmd_ready_out) begin
      if (cmd_kind_in == CMD_CONTROL) begin
        ctl_done_r <= 1'b1;
      end
      if (cmd_kind_in == CMD_ADDRESS && ctl_done_r) begin
        addr_done_r <= 1'b1;
      end
    end
  end

  // One state machine owns the whole pair so nothing can interleave with it.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= ST_IDLE;
      kind_r <= CMD_CONTROL;
      word_r <= '0;
      be_r <= 4'h0;
      second_r <= 1'b0;
      hp.reg_select <= SEL_CONTROL;
      hp.read_not_write <= 1'b1;
      hp.chip_select_n <= 1'b1;
      hp.data_strobe_n <= 1'b1;
      hp.halfword_identify <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (cmd_valid_in && cmd_ready_out) begin
            kind_r <= cmd_kind_in;
            word_r <= cmd_data_in;
            be_r <= (cmd_kind_in == CMD_WRITE) ? cmd_byte_en_in : 4'hF;
            second_r <= 1'b0;
            hp.reg_select <= sel_for(cmd_kind_in);
            hp.read_not_write <= (cmd_kind_in == CMD_READ);
            hp.halfword_identify <= 1'b0;
            state_r <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          hp.chip_select_n <= 1'b0;
          hp.data_strobe_n <= 1'b0;
          state_r <= ST_STROBE;
        end
        ST_STROBE: begin
          // The ready pin is the only source of wait states.
          if (!hp.port_ready_n) begin
            hp.data_strobe_n <= 1'b1;
            state_r <= ST_RELEASE;
          end
        end
        ST_RELEASE: begin
          if (!second_r) begin
            hp.halfword_identify <= 1'b1;
            second_r <= 1'b1;
            state_r <= ST_SETUP;
          end else begin
            hp.chip_select_n <= 1'b1;
            hp.halfword_identify <= 1'b0;
            state_r <= (kind_r == CMD_READ) ? ST_PUSH : ST_IDLE;
          end
        end
        ST_PUSH: begin
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // The bus is only driven between setup and release, so a read never fights the far end.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hp.bus_from_bridge <= 16'h0000;
      hp.bus_from_bridge_oe <= 1'b0;
      hp.byte_enable_0_n <= 1'b1;
      hp.byte_enable_1_n <= 1'b1;
    end else if (state_r == ST_SETUP) begin
      if (kind_r != CMD_READ) begin
        hp.bus_from_bridge_oe <= 1'b1;
        hp.bus_from_bridge <= half_pick(word_r, second_r);
        hp.byte_enable_0_n <= ~lane_on(be_r, second_r, 1'b0);
        hp.byte_enable_1_n <= ~lane_on(be_r, second_r, 1'b1);
      end else begin
        hp.byte_enable_0_n <= 1'b0;
        hp.byte_enable_1_n <= 1'b0;
      end
    end else if (state_r == ST_RELEASE) begin
      hp.bus_from_bridge_oe <= 1'b0;
      hp.byte_enable_0_n <= 1'b1;
      hp.byte_enable_1_n <= 1'b1;
    end
  end

  // Each half is caught on the edge that sees ready, while the far end still drives the bus.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_word_r <= '0;
    end else if (state_r == ST_STROBE && !hp.port_ready_n && kind_r == CMD_READ) begin
      if (second_r) begin
        rd_word_r[31:16] <= hp.muxed_bus;
      end else begin
        rd_word_r[15:0] <= hp.muxed_bus;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      push_valid_r <= 1'b0;
    end else begin
      push_valid_r <= (state_r == ST_RELEASE) && second_r && (kind_r == CMD_READ);
    end
  end

  // Read words wait here; a full buffer stops new commands from being taken.
  word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) read_buf (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(push_valid_r),
    .in_ready_out(fifo_ready),
    .in_data_in(rd_word_r),
    .out_valid_out(rd_valid_out),
    .out_ready_in(rd_ready_in),
    .out_data_out(rd_data_out)
  );
endmodule // host_port_bridge
`default_nettype wire

/* File: verilog/host_port_dsp.sv */
`timescale 1ns/1ps
`default_nettype none
module host_port_dsp (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic core_reset_in,
  output logic [hport_pkg::WORD_W-1:0] control_out,
  output logic [hport_pkg::WORD_W-1:0] address_out,
  output logic word_valid_out,
  output logic [hport_pkg::WORD_W-1:0] word_out,
  output logic [3:0] word_be_out,
  output logic [hport_pkg::WORD_W-1:0] read_fetch_addr_out,
  input wire logic [hport_pkg::WORD_W-1:0] read_word_in,
  output logic pair_lost_out,
  host_port_if.dsp hp
);
  import hport_pkg::*;
  logic strobe_d_r;
  logic [1:0] sel_r;
  logic rnw_r;
  logic half_r;
  logic first_seen_r;
  logic [15:0] low_r;
  logic [1:0] low_be_r;
  logic [3:0] wait_r;
  logic [WORD_W-1:0] ctl_r;
  logic [WORD_W-1:0] addr_r;
  logic strobe_fall;
  logic strobe_rise;
  logic active;
  assign strobe_fall = strobe_d_r && !hp.data_strobe_n;
  assign strobe_rise = !strobe_d_r && hp.data_strobe_n;
  // A core held in reset answers nothing, so the bridge simply waits.
  assign active = !hp.chip_select_n && !core_reset_in;
  assign control_out = ctl_r;
  assign address_out = addr_r;
  assign read_fetch_addr_out = addr_r;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strobe_d_r <= 1'b1;
      sel_r <= SEL_CONTROL;
      rnw_r <= 1'b1;
      half_r <= 1'b0;
      first_seen_r <= 1'b0;
      low_r <= 16'h0000;
      low_be_r <= 2'h0;
      wait_r <= 4'h0;
      ctl_r <= CONTROL_RESET;
      addr_r <= ADDRESS_RESET;
      word_valid_out <= 1'b0;
      word_out <= '0;
      word_be_out <= 4'h0;
      pair_lost_out <= 1'b0;
      hp.port_ready_n <= 1'b1;
      hp.bus_from_dsp <= 16'h0000;
      hp.bus_from_dsp_oe <= 1'b0;
    end else begin
      strobe_d_r <= hp.data_strobe_n;
      word_valid_out <= 1'b0;
      pair_lost_out <= 1'b0;
      if (strobe_fall && active) begin
        sel_r <= hp.reg_select;
        rnw_r <= hp.read_not_write;
        half_r <= hp.halfword_identify;
        wait_r <= DSP_WAIT_CYCLES;
        hp.port_ready_n <= 1'b1;
        if (hp.halfword_identify && !first_seen_r) begin
          pair_lost_out <= 1'b1;
        end
        if (hp.read_not_write) begin
          hp.bus_from_dsp_oe <= 1'b1;
          hp.bus_from_dsp <= hp.halfword_identify ? read_word_in[31:16] : read_word_in[15:0];
        end
      end else if (!hp.data_strobe_n && active) begin
        if (wait_r != 4'h0) begin
          wait_r <= wait_r - 4'h1;
        end else begin
          hp.port_ready_n <= 1'b0;
        end
      end
      if (strobe_rise) begin
        hp.port_ready_n <= 1'b1;
        hp.bus_from_dsp_oe <= 1'b0;
        if (!half_r) begin
          first_seen_r <= 1'b1;
          low_r <= hp.muxed_bus;
          low_be_r <= {~hp.byte_enable_1_n, ~hp.byte_enable_0_n};
        end else begin
          first_seen_r <= 1'b0;
          if (first_seen_r && !rnw_r) begin
            case (sel_r)
              SEL_CONTROL: ctl_r <= {hp.muxed_bus, low_r};
              SEL_ADDRESS: addr_r <= {hp.muxed_bus, low_r};
              default: begin
                word_valid_out <= 1'b1;
                word_out <= {hp.muxed_bus, low_r};
                word_be_out <= {~hp.byte_enable_1_n, ~hp.byte_enable_0_n, low_be_r};
              end
            endcase
          end
          if (sel_r == SEL_DATA_INC) begin
            addr_r <= addr_r + 32'h0000_0004;
          end
        end
      end
      if (hp.chip_select_n && first_seen_r && strobe_d_r) begin
        first_seen_r <= 1'b0;
        pair_lost_out <= 1'b1;
      end
    end
  end
endmodule // host_port_dsp
`default_nettype wire

/* File: verilog/host_port_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface host_port_if;
  logic [1:0] reg_select;
  logic read_not_write;
  logic chip_select_n;
  logic data_strobe_n;
  logic halfword_identify;
  logic byte_enable_0_n;
  logic byte_enable_1_n;
  logic [15:0] bus_from_bridge;
  logic bus_from_bridge_oe;
  logic [15:0] bus_from_dsp;
  logic bus_from_dsp_oe;
  logic port_ready_n;
  wire [15:0] muxed_bus = bus_from_bridge_oe ? bus_from_bridge : (bus_from_dsp_oe ? bus_from_dsp : 16'h0000);
  modport bridge (
    output reg_select, read_not_write, chip_select_n, data_strobe_n, halfword_identify,
    output byte_enable_0_n, byte_enable_1_n, bus_from_bridge, bus_from_bridge_oe,
    input muxed_bus, port_ready_n
  );
  modport dsp (
    input reg_select, read_not_write, chip_select_n, data_strobe_n, halfword_identify,
    input byte_enable_0_n, byte_enable_1_n, muxed_bus,
    output bus_from_dsp, bus_from_dsp_oe, port_ready_n
  );
endinterface
`default_nettype wire

/* File: verilog/hport_pkg.sv */
package hport_pkg;
  localparam int WORD_W = 32;
  localparam int HALF_W = 16;
  localparam int FIFO_DEPTH = 8;
  // Register select codes on reg_select_1/reg_select_0.
  localparam logic [1:0] SEL_CONTROL = 2'h0;
  localparam logic [1:0] SEL_ADDRESS = 2'h1;
  localparam logic [1:0] SEL_DATA_INC = 2'h2;
  localparam logic [1:0] SEL_DATA_NOINC = 2'h3;
  // Reset values of the far end's control and address registers.
  localparam logic [WORD_W-1:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [WORD_W-1:0] ADDRESS_RESET = 32'h0000_0000;
  // Wait cycles the model of the DSP inserts before reporting ready.
  localparam logic [3:0] DSP_WAIT_CYCLES = 4'h2;
  localparam int CMD_W = 2;
  localparam logic [CMD_W-1:0] CMD_CONTROL = 2'h0;
  localparam logic [CMD_W-1:0] CMD_ADDRESS = 2'h1;
  localparam logic [CMD_W-1:0] CMD_WRITE = 2'h2;
  localparam logic [CMD_W-1:0] CMD_READ = 2'h3;
endpackage

/* File: verilog/word_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;
  assign push = in_valid_in && (count_r != (AW+1)'(DEPTH));
  assign pop = out_valid_out && out_ready_in;
  assign in_ready_out = (count_r != (AW+1)'(DEPTH));
  assign out_valid_out = (count_r != '0);
  assign out_data_out = mem_r[rd_r];
  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem_r[wr_r] <= in_data_in;
    end
  end
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_r <= '0;
      rd_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // word_fifo
`default_nettype wire
